// file: timer8_compare_unit.sv
// 8-bit timer/counter with one compare channel and a plain register port
// Assumes a synchronous single-cycle master on i_mclk; ext pin is async
//
// Function
// - Each tick clears, increments or decrements the counter per mode.
// - Clock select zero gives no tick; counter stays stopped.
// - CPU can read and write the counter at any time.
// - CPU counter write beats any same-cycle clear or count.
// - Top flag at maximum value, bottom flag at zero.
// - Waveform mode bits in control A set the counting sequence.
// - Overflow flag set per mode; may raise a CPU interrupt.
// - Comparator flags a match whenever counter equals compare value.
// - Compare flag sets on the tick following the match.
// - Compare interrupt needs flag, its enable and global enable.
// - Compare flag clears when its interrupt is serviced.
// - Writing one clears compare flag; writing zero keeps it.
// - Action field zero leaves the output alone on match.
// - New action value acts from the first match after the write.
// - Force strobe applies the action at once in non-PWM modes.
// - Action bits never change counting; mode bits do.
// - In PWM modes action bits pick inverted or non-inverted output.
// - In non-PWM modes action bits set, clear or toggle on match.
// - Mode zero counts up without clearing, wrapping max to zero.
// - Normal overflow sets as counter becomes zero; ack clears it.
// - Normal mode accepts counter writes at any time.
// - Mode two clears the counter on compare match.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "timer8_map.svh"

module timer8_compare_unit
    import timer8_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire reg_req_s i_bus,
    output logic [7:0] o_rdata,
    input wire logic i_ext_clk,
    input wire logic i_global_int_en,
    input wire logic i_ovf_ack,
    input wire logic i_cmp_ack,
    output logic o_ovf_irq,
    output logic o_cmp_irq,
    output logic o_cmp_pin
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // PWM modes are the odd encodings
    function automatic logic is_pwm(input wave_mode_e m);
        is_pwm = (m == WAVE_PHASE_PWM) || (m == WAVE_FAST_PWM);
    endfunction : is_pwm

    // Non-PWM action: 1 toggle, 2 clear, 3 set, 0 hold
    function automatic logic act_out(input logic [1:0] a,
                                     input logic cur);
        unique case (a)
            2'h0: act_out = cur;
            2'h1: act_out = ~cur;
            2'h2: act_out = 1'b0;
            2'h3: act_out = 1'b1;
        endcase
    endfunction : act_out

    // True when the low tap bits of the prescaler are all ones
    function automatic logic tap_done(input logic [9:0] p,
                                      input int unsigned n);
        logic [9:0] m;
        m = 10'((11'h001 << n) - 11'h001);
        tap_done = (p & m) == m;
    endfunction : tap_done

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    wave_mode_e wave_r, wave_nxt;
    logic [1:0] action_r, action_nxt;
    logic [2:0] cs_r, cs_nxt;
    logic [7:0] count_r, count_nxt;
    logic [7:0] compare_r, compare_nxt;
    logic ovf_en_r, ovf_en_nxt;
    logic cmp_en_r, cmp_en_nxt;
    logic ovf_flag_r, ovf_flag_nxt;
    logic cmp_flag_r, cmp_flag_nxt;
    logic down_r, down_nxt;
    logic block_r, block_nxt;
    logic pin_r, pin_nxt;
    logic [9:0] presc_r, presc_nxt;
    logic ext_meta_r, ext_sync_r, ext_prev_r;
    logic [7:0] rdata_r, rdata_nxt;
    logic ovf_irq_r, cmp_irq_r;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire wr_ca = i_bus.wr && (i_bus.addr == `T8_OFS_CTRL_A);
    wire wr_cb = i_bus.wr && (i_bus.addr == `T8_OFS_CTRL_B);
    wire wr_cnt = i_bus.wr && (i_bus.addr == `T8_OFS_COUNT);
    wire wr_cmp = i_bus.wr && (i_bus.addr == `T8_OFS_COMPARE);
    wire wr_ien = i_bus.wr && (i_bus.addr == `T8_OFS_IRQ_EN);
    wire wr_fl = i_bus.wr && (i_bus.addr == `T8_OFS_FLAGS);
    wire force_stb = wr_cb && i_bus.wdata[`T8_CB_FORCE_BIT];
    wire clr_ovf = wr_fl && i_bus.wdata[`T8_FL_OVF_BIT];
    wire clr_cmp = wr_fl && i_bus.wdata[`T8_FL_CMP_BIT];

    assign wave_nxt = wr_ca ?
        wave_mode_e'(i_bus.wdata[`T8_CA_WAVE_LSB +: 2]) : wave_r;
    // The action field is only sampled at match, force or fast PWM top, so a write
    // naturally applies from the next match onward
    assign action_nxt = wr_ca ?
        i_bus.wdata[`T8_CA_ACT_LSB +: 2] : action_r;
    assign cs_nxt = wr_cb ? i_bus.wdata[`T8_CB_CS_LSB +: 3] : cs_r;
    assign compare_nxt = wr_cmp ? i_bus.wdata : compare_r;
    assign ovf_en_nxt = wr_ien ? i_bus.wdata[`T8_FL_OVF_BIT] : ovf_en_r;
    assign cmp_en_nxt = wr_ien ? i_bus.wdata[`T8_FL_CMP_BIT] : cmp_en_r;

    // ----------------------------------------------------------------
    // Tick generation
    // ----------------------------------------------------------------
    // Prescaler only runs while a source is picked, so each start
    // begins a full divided period
    assign presc_nxt = (cs_r == 3'h0) ? 10'h000 : presc_r + 10'h001;
    wire ext_fall = ext_prev_r && !ext_sync_r;
    wire ext_rise = !ext_prev_r && ext_sync_r;
    logic tick;
    always_comb begin
        unique case (cs_r)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = tap_done(presc_r, `T8_TAP_8);
            3'h3: tick = tap_done(presc_r, `T8_TAP_64);
            3'h4: tick = tap_done(presc_r, `T8_TAP_256);
            3'h5: tick = tap_done(presc_r, `T8_TAP_1024);
            3'h6: tick = ext_fall;
            3'h7: tick = ext_rise;
        endcase
    end

    // ----------------------------------------------------------------
    // Counter unit
    // ----------------------------------------------------------------
    wire at_top = (count_r == `T8_COUNT_MAX);
    wire at_bottom = (count_r == 8'h00);
    wire match = (count_r == compare_r);
    // A counter write suppresses the match on the following tick
    wire cmp_hit = tick && match && !block_r;
    wire pwm = is_pwm(wave_r);

    // Next count per mode; action bits play no part here
    logic [7:0] step;
    always_comb begin
        step = count_r + 8'h01;
        down_nxt = down_r;
        unique case (wave_r)
            WAVE_NORMAL: step = count_r + 8'h01;
            WAVE_FAST_PWM: step = count_r + 8'h01;
            WAVE_CTC: step = match ? 8'h00 : count_r + 8'h01;
            WAVE_PHASE_PWM: begin
                if (at_top) begin
                    down_nxt = 1'b1;
                end else if (at_bottom) begin
                    down_nxt = 1'b0;
                end
                step = (down_nxt ? count_r - 8'h01 : count_r + 8'h01);
            end
        endcase
        if (!tick || wave_r != WAVE_PHASE_PWM) begin
            down_nxt = (wave_r == WAVE_PHASE_PWM) ? down_r : 1'b0;
        end
    end

    // CPU write first, then tick, else hold
    assign count_nxt = wr_cnt ? i_bus.wdata :
                       tick ? step : count_r;
    assign block_nxt = wr_cnt ? 1'b1 : (tick ? 1'b0 : block_r);

    // ----------------------------------------------------------------
    // Flags: a set in the same cycle as a clear wins
    // ----------------------------------------------------------------
    wire ovf_set = tick && !wr_cnt && (wave_r == WAVE_PHASE_PWM ?
                   (down_r && at_bottom) : at_top);
    assign ovf_flag_nxt = ovf_set ||
        (ovf_flag_r && !clr_ovf && !i_ovf_ack);
    assign cmp_flag_nxt = cmp_hit ||
        (cmp_flag_r && !clr_cmp && !i_cmp_ack);

    // ----------------------------------------------------------------
    // Waveform output
    // ----------------------------------------------------------------
    always_comb begin
        pin_nxt = pin_r;
        if (!pwm) begin
            // Force gives the match action without flag or clear
            if (cmp_hit || force_stb) begin
                pin_nxt = act_out(action_r, pin_r);
            end
        end else if (action_r[1]) begin
            // Action 2 non-inverted, 3 inverted; 0 and 1 leave the pin
            if (cmp_hit) begin
                pin_nxt = (wave_r == WAVE_PHASE_PWM && down_r) ?
                          !action_r[0] : action_r[0];
            end else if (tick && at_top &&
                         wave_r == WAVE_FAST_PWM) begin
                pin_nxt = !action_r[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read mux; the force bit always reads back as zero
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                `T8_OFS_CTRL_A: rdata_nxt = {2'h0, action_r, 2'h0, wave_r};
                `T8_OFS_CTRL_B: rdata_nxt = {5'h00, cs_r};
                `T8_OFS_COUNT: rdata_nxt = count_r;
                `T8_OFS_COMPARE: rdata_nxt = compare_r;
                `T8_OFS_IRQ_EN: rdata_nxt = {6'h00, cmp_en_r, ovf_en_r};
                `T8_OFS_FLAGS: rdata_nxt = {6'h00, cmp_flag_r, ovf_flag_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Flip-flops
    // ----------------------------------------------------------------
    // External pin synchroniser; the second and third stages feed the edge detect
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            ext_meta_r <= i_ext_clk;
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
        end
    end

    // Control and configuration registers, all zero at reset
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wave_r <= WAVE_NORMAL;
            action_r <= 2'h0;
            cs_r <= 3'h0;
            compare_r <= `T8_RST_BYTE;
            ovf_en_r <= 1'b0;
            cmp_en_r <= 1'b0;
        end else begin
            wave_r <= wave_nxt;
            action_r <= action_nxt;
            cs_r <= cs_nxt;
            compare_r <= compare_nxt;
            ovf_en_r <= ovf_en_nxt;
            cmp_en_r <= cmp_en_nxt;
        end
    end

    // Counting state and flags
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            count_r <= `T8_RST_BYTE;
            presc_r <= 10'h000;
            down_r <= 1'b0;
            block_r <= 1'b0;
            ovf_flag_r <= 1'b0;
            cmp_flag_r <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            presc_r <= presc_nxt;
            down_r <= down_nxt;
            block_r <= block_nxt;
            ovf_flag_r <= ovf_flag_nxt;
            cmp_flag_r <= cmp_flag_nxt;
            pin_r <= pin_nxt;
        end
    end

    // Registered outputs; requests need flag, enable and global enable
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= 8'h00;
            ovf_irq_r <= 1'b0;
            cmp_irq_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            ovf_irq_r <= ovf_flag_r && ovf_en_r && i_global_int_en;
            cmp_irq_r <= cmp_flag_r && cmp_en_r && i_global_int_en;
        end
    end

    assign o_rdata = rdata_r;
    assign o_ovf_irq = ovf_irq_r;
    assign o_cmp_irq = cmp_irq_r;
    assign o_cmp_pin = pin_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    stop_hold_a: assert property (
        (cs_r == 3'h0 && !wr_cnt) |=> count_r == $past(count_r))
        else $error("Counter moved while stopped");

    cpu_write_a: assert property (
        wr_cnt |=> count_r == $past(i_bus.wdata))
        else $error("Counter write lost");

    flag_set_a: assert property (
        (tick && match && !block_r) |=> cmp_flag_r)
        else $error("Compare flag not set after match");

    irq_gate_a: assert property (
        o_cmp_irq == $past(cmp_flag_r && cmp_en_r && i_global_int_en))
        else $error("Compare request without all enables");

    ack_clear_a: assert property (
        (i_cmp_ack && !cmp_hit) |=> !cmp_flag_r)
        else $error("Compare flag not cleared by service");

    soft_clear_a: assert property (
        (wr_fl && !i_bus.wdata[1] && cmp_flag_r && !i_cmp_ack) |=> cmp_flag_r)
        else $error("Writing zero cleared compare flag");

    no_action_a: assert property (
        (!pwm && action_r == 2'h0) |=> o_cmp_pin == $past(o_cmp_pin))
        else $error("Output moved with no action");

    force_toggle_a: assert property (
        (force_stb && !pwm && action_r == 2'h1 && !cmp_hit)
        |=> o_cmp_pin != $past(o_cmp_pin))
        else $error("Force strobe did not toggle");

    normal_wrap_a: assert property (
        (tick && wave_r == WAVE_NORMAL && at_top && !wr_cnt)
        |=> count_r == 8'h00 && ovf_flag_r)
        else $error("Normal wrap or overflow wrong");

    ctc_clear_a: assert property (
        (tick && wave_r == WAVE_CTC && match && !wr_cnt)
        |=> count_r == 8'h00)
        else $error("Match mode did not clear counter");

    run_tick_a: assert property (
        (cs_r == 3'h1 && wave_r == WAVE_NORMAL && !wr_cnt)
        |=> count_r == 8'($past(count_r) + 8'h01))
        else $error("Counter did not step on tick");

    // Service of the overflow request drops the flag unless a new one lands
    ovf_ack_a: assert property (
        (i_ovf_ack && !ovf_set) |=> !ovf_flag_r)
        else $error("Overflow flag not cleared by service");

    // Hardware only sets the overflow flag; only a service ack or a write of one may drop it
    ovf_hold_a: assert property (
        (ovf_flag_r && !ovf_set && !i_ovf_ack && !clr_ovf) |=> ovf_flag_r)
        else $error("Overflow flag lost without a clear");

    count_read_a: assert property (
        (i_bus.rd && i_bus.addr == `T8_OFS_COUNT) |=> o_rdata == $past(count_r))
        else $error("Counter read returned wrong value");

    // Force is a non-PWM feature; in PWM the pin only follows the count
    pwm_force_a: assert property (
        (force_stb && pwm && !tick) |=> o_cmp_pin == $past(o_cmp_pin))
        else $error("Force strobe moved a PWM output");

endmodule : timer8_compare_unit
`default_nettype wire

// file: timer8_map.svh
// Register offsets, field positions, reset values and prescale taps
// Included by the timer module; holds definitions only
`ifndef TIMER8_MAP_SVH
`define TIMER8_MAP_SVH
`define T8_ADDR_W 3
`define T8_OFS_CTRL_A 3'h0
`define T8_OFS_CTRL_B 3'h1
`define T8_OFS_COUNT 3'h2
`define T8_OFS_COMPARE 3'h3
`define T8_OFS_IRQ_EN 3'h4
`define T8_OFS_FLAGS 3'h5
`define T8_CA_WAVE_LSB 0
`define T8_CA_ACT_LSB 4
`define T8_CB_CS_LSB 0
`define T8_CB_FORCE_BIT 7
`define T8_FL_OVF_BIT 0
`define T8_FL_CMP_BIT 1
`define T8_RST_BYTE 8'h00
`define T8_COUNT_MAX 8'hFF
`define T8_TAP_8 3
`define T8_TAP_64 6
`define T8_TAP_256 8
`define T8_TAP_1024 10
`endif

// file: timer8_pkg.sv
// Types shared by the timer/counter block
// Assumes the map header supplies the widths
`include "timer8_map.svh"
package timer8_pkg;
    typedef enum logic [1:0] {
        WAVE_NORMAL,
        WAVE_PHASE_PWM,
        WAVE_CTC,
        WAVE_FAST_PWM
    } wave_mode_e;
    typedef struct packed {
        logic [`T8_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
endpackage : timer8_pkg

// file: timer8_compare_unit_tb.sv
// Self-checking testbench for the 8-bit timer/counter with one compare channel
// Assumes the timer module, its package and its map header are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "timer8_map.svh"

module testbench
    import timer8_pkg::*;
;
    logic i_mclk;
    logic i_rst;
    reg_req_s bus;
    logic [7:0] o_rdata;
    logic i_ext_clk;
    logic i_global_int_en;
    logic i_ovf_ack;
    logic i_cmp_ack;
    logic o_ovf_irq;
    logic o_cmp_irq;
    logic o_cmp_pin;
    int fail_count = 0;
    int n_checks = 0;

    // ----------------------------------------
    // Device under test
    // ----------------------------------------
    // External count pin idles low; only the source scenario toggles it
    timer8_compare_unit uut (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_bus(bus),
        .o_rdata(o_rdata),
        .i_ext_clk(i_ext_clk),
        .i_global_int_en(i_global_int_en),
        .i_ovf_ack(i_ovf_ack),
        .i_cmp_ack(i_cmp_ack),
        .o_ovf_irq(o_ovf_irq),
        .o_cmp_irq(o_cmp_irq),
        .o_cmp_pin(o_cmp_pin)
    );

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    // Whole run is a few hundred cycles; 20000 leaves ample margin
    initial begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        finish_test();
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Leaves the write strobe up so that writes can follow back to back
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask : wr_reg

    task automatic idle(input int n);
        @(posedge i_mclk);
        bus <= '0;
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : idle

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        bus <= '0;
        #1;
        chk(o_rdata, exp);
    endtask : rd_chk

    task automatic bit_chk(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask : bit_chk

    // Clock select s held for exactly n cycles, then stop; the strobe
    // drops after one cycle so the select write is not repeated
    task automatic run_sel(input logic [7:0] s, input int n);
        wr_reg(`T8_OFS_CTRL_B, s);
        if (n > 1) begin
            @(posedge i_mclk);
            bus <= '0;
            repeat (n - 2) @(posedge i_mclk);
        end
        wr_reg(`T8_OFS_CTRL_B, 8'h00);
        idle(2);
    endtask : run_sel

    // Clock select 1 held for n cycles gives exactly n ticks
    task automatic run_ticks(input int n);
        run_sel(8'h01, n);
    endtask : run_ticks

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        for (int a = 0; a < 8; a++) begin
            rd_chk(a[2:0], `T8_RST_BYTE);
        end
        bit_chk(o_cmp_pin, 1'b0);
    endtask : t_reset

    task automatic t_stopped();
        wr_reg(`T8_OFS_COUNT, 8'h5A);
        idle(10);
        rd_chk(`T8_OFS_COUNT, 8'h5A);
    endtask : t_stopped

    task automatic t_overflow();
        wr_reg(`T8_OFS_IRQ_EN, 8'h01);
        wr_reg(`T8_OFS_COUNT, 8'hFF);
        run_ticks(1);
        rd_chk(`T8_OFS_COUNT, 8'h00);
        rd_chk(`T8_OFS_FLAGS, 8'h01);
        bit_chk(o_ovf_irq, 1'b0);
        @(posedge i_mclk);
        i_global_int_en <= 1'b1;
        idle(3);
        bit_chk(o_ovf_irq, 1'b1);
        @(posedge i_mclk);
        i_ovf_ack <= 1'b1;
        @(posedge i_mclk);
        i_ovf_ack <= 1'b0;
        idle(3);
        rd_chk(`T8_OFS_FLAGS, 8'h00);
        bit_chk(o_ovf_irq, 1'b0);
        @(posedge i_mclk);
        i_global_int_en <= 1'b0;
    endtask : t_overflow

    // Write lands in a tick cycle; the tick in the following cycle still counts
    task automatic t_priority();
        wr_reg(`T8_OFS_COUNT, 8'h10);
        wr_reg(`T8_OFS_CTRL_B, 8'h01);
        wr_reg(`T8_OFS_COUNT, 8'h80);
        wr_reg(`T8_OFS_CTRL_B, 8'h00);
        idle(2);
        rd_chk(`T8_OFS_COUNT, 8'h81);
    endtask : t_priority

    task automatic t_ctc();
        wr_reg(`T8_OFS_COMPARE, 8'h03);
        wr_reg(`T8_OFS_COUNT, 8'h00);
        wr_reg(`T8_OFS_IRQ_EN, 8'h02);
        wr_reg(`T8_OFS_CTRL_A, 8'h12);
        run_ticks(3);
        rd_chk(`T8_OFS_COUNT, 8'h03);
        rd_chk(`T8_OFS_FLAGS, 8'h00);
        bit_chk(o_cmp_pin, 1'b0);
        run_ticks(1);
        rd_chk(`T8_OFS_COUNT, 8'h00);
        rd_chk(`T8_OFS_FLAGS, 8'h02);
        bit_chk(o_cmp_pin, 1'b1);
        bit_chk(o_cmp_irq, 1'b0);
        @(posedge i_mclk);
        i_global_int_en <= 1'b1;
        idle(3);
        bit_chk(o_cmp_irq, 1'b1);
        @(posedge i_mclk);
        i_cmp_ack <= 1'b1;
        @(posedge i_mclk);
        i_cmp_ack <= 1'b0;
        idle(3);
        rd_chk(`T8_OFS_FLAGS, 8'h00);
        bit_chk(o_cmp_irq, 1'b0);
        @(posedge i_mclk);
        i_global_int_en <= 1'b0;
        run_ticks(4);
        bit_chk(o_cmp_pin, 1'b0);
        wr_reg(`T8_OFS_FLAGS, 8'h00);
        rd_chk(`T8_OFS_FLAGS, 8'h02);
        wr_reg(`T8_OFS_FLAGS, 8'h02);
        rd_chk(`T8_OFS_FLAGS, 8'h00);
    endtask : t_ctc

    // Force in clear-on-match mode, then in normal mode, with count at the compare value
    task automatic t_force();
        wr_reg(`T8_OFS_COUNT, 8'h03);
        wr_reg(`T8_OFS_CTRL_A, 8'h32);
        wr_reg(`T8_OFS_CTRL_B, 8'h80);
        idle(2);
        bit_chk(o_cmp_pin, 1'b1);
        rd_chk(`T8_OFS_COUNT, 8'h03);
        rd_chk(`T8_OFS_FLAGS, 8'h00);
        rd_chk(`T8_OFS_CTRL_B, 8'h00);
        wr_reg(`T8_OFS_CTRL_A, 8'h02);
        wr_reg(`T8_OFS_CTRL_B, 8'h80);
        idle(2);
        bit_chk(o_cmp_pin, 1'b1);
        wr_reg(`T8_OFS_CTRL_A, 8'h20);
        wr_reg(`T8_OFS_CTRL_B, 8'h80);
        idle(2);
        bit_chk(o_cmp_pin, 1'b0);
    endtask : t_force

    task automatic t_pwm();
        wr_reg(`T8_OFS_COMPARE, 8'h10);
        wr_reg(`T8_OFS_COUNT, 8'h0F);
        wr_reg(`T8_OFS_CTRL_A, 8'h33);
        run_ticks(2);
        bit_chk(o_cmp_pin, 1'b1);
        wr_reg(`T8_OFS_COUNT, 8'h0F);
        wr_reg(`T8_OFS_CTRL_A, 8'h23);
        run_ticks(2);
        bit_chk(o_cmp_pin, 1'b0);
        wr_reg(`T8_OFS_CTRL_A, 8'h33);
        wr_reg(`T8_OFS_CTRL_B, 8'h80);
        idle(2);
        bit_chk(o_cmp_pin, 1'b0);
    endtask : t_pwm

    // Phase PWM turns at the top, the divide-by-8 tap, then both pin edges;
    // pin levels are held 4 cycles to get through the synchroniser
    task automatic t_sources();
        wr_reg(`T8_OFS_CTRL_A, 8'h01);
        wr_reg(`T8_OFS_COUNT, 8'hFE);
        run_ticks(3);
        rd_chk(`T8_OFS_COUNT, 8'hFD);
        wr_reg(`T8_OFS_CTRL_A, 8'h00);
        wr_reg(`T8_OFS_COUNT, 8'h00);
        run_sel(8'h02, 19);
        rd_chk(`T8_OFS_COUNT, 8'h02);
        for (int s = 6; s < 8; s++) begin
            wr_reg(`T8_OFS_COUNT, 8'h00);
            wr_reg(`T8_OFS_CTRL_B, 8'(s));
            @(posedge i_mclk);
            bus <= '0;
            repeat (3) begin
                i_ext_clk <= 1'b1;
                repeat (4) @(posedge i_mclk);
                i_ext_clk <= 1'b0;
                repeat (4) @(posedge i_mclk);
            end
            wr_reg(`T8_OFS_CTRL_B, 8'h00);
            idle(2);
            rd_chk(`T8_OFS_COUNT, 8'h03);
        end
    endtask : t_sources

    // ----------------------------------------
    // Verdict and main sequence
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        i_rst = 1'b1;
        bus = '0;
        i_ext_clk = 1'b0;
        i_global_int_en = 1'b0;
        i_ovf_ack = 1'b0;
        i_cmp_ack = 1'b0;
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_reset();
        t_stopped();
        t_overflow();
        t_priority();
        t_ctc();
        t_force();
        t_pwm();
        t_sources();
        finish_test();
    end
endmodule : testbench

`default_nettype wire
